/* tcic_pkg.sv */
package tcic_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CNT_HI  = 8'h00;
  localparam logic [7:0] OFS_CNT_LO  = 8'h04;
  localparam logic [7:0] OFS_ALT_HI  = 8'h08;
  localparam logic [7:0] OFS_ALT_LO  = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_CTRL1   = 8'h14;
  localparam logic [7:0] OFS_CTRL2   = 8'h18;
  localparam logic [7:0] OFS_CAP1_HI = 8'h1c;
  localparam logic [7:0] OFS_CAP1_LO = 8'h20;
  localparam logic [7:0] OFS_CAP2_HI = 8'h24;
  localparam logic [7:0] OFS_CAP2_LO = 8'h28;

  // ----------------------------------------------------------------
  // Values and field positions
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_RELOAD  = 16'hfffc;
  localparam logic [15:0] CNT_TOP     = 16'hffff;
  localparam logic [1:0]  CS_EXTERNAL = 2'h3;
  localparam int          ST_OVF      = 0;
  localparam int          ST_CAP1     = 1;
  localparam int          ST_CAP2     = 2;
  localparam logic [2:0]  MASK_DIV2   = 3'h1;
  localparam logic [2:0]  MASK_DIV4   = 3'h3;
  localparam logic [2:0]  MASK_DIV8   = 3'h7;

  // ----------------------------------------------------------------
  // Control register layouts, bit 0 last
  // ----------------------------------------------------------------
  typedef struct packed {
    logic edge_one;
    logic cap_ie;
    logic ovf_ie;
  } tcic_ctrl1_type;

  typedef struct packed {
    logic       pwm;
    logic       one_pulse;
    logic       edge_two;
    logic       ext_edge;
    logic [1:0] clock_select;
  } tcic_ctrl2_type;

endpackage

/* tcic_top.sv */
`timescale 1ns/1ps
// What this block does
// R1 - Sixteen-bit up-counter read as two bytes
// R2 - Alternate image; its low read keeps overflow
// R3 - Low byte write reloads counter to FFFCh
// R4 - Reset and reload value is always FFFCh
// R5 - Counter clock: divide 2, 4, 8, external
// R6 - High read latches low until low read
// R7 - Rollover FFFFh to 0000h sets overflow flag
// R8 - Overflow request gated by enable and mask
// R9 - Overflow clears: status read, then main low
// R10 - Runs in wait, freezes in halt
// R11 - Both select bits one picks external edge
// R12 - External edges synchronised to the clock; the code compares the raw pin with one registered copy, no sync stage
// R13 - External edges four clocks apart at least
// R14 - Capture latches counter on active pin edge
// R15 - Each channel has own edge select
// R16 - Capture sets flag; one shared enable
// R17 - Capture request gated by enable and mask
// R18 - Capture flag clears: status, then low byte
// R19 - High read blocks captures until low read
// R20 - One-pulse or PWM: only channel two captures
// R21 - Either pin edge, as selected, may trigger capture
// R22 - Capture flag two clocks after pin event
// R23 - Divider code mapping is a parameter
module tcic_top
  import tcic_pkg::*;
#(
  parameter logic [1:0] CODE_DIV2 = 2'h0,
  parameter logic [1:0] CODE_DIV4 = 2'h1,
  parameter logic [1:0] CODE_DIV8 = 2'h2
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_irq_mask,
  input  wire logic        halt_mode,
  input  wire logic        external_clock_pin,
  input  wire logic        capture_pin_one,
  input  wire logic        capture_pin_two,
  output logic             overflow_irq,
  output logic             capture_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
    edge_hit = rise ? (~prev & cur) : (prev & ~cur);
  endfunction
  function automatic logic div_mask_ok(input logic [2:0] pre, input logic [2:0] mask);
    div_mask_ok = (pre & mask) == mask;
  endfunction

  logic [15:0]    cnt_reg;
  logic [7:0]     low_latch_reg;
  logic           seq_reg;
  logic [2:0]     pre_reg;
  logic           ext_prev_reg;
  logic [1:0]     pin_s_reg;
  logic [1:0]     pin_prev_reg;
  logic [15:0]    cap1_reg;
  logic [15:0]    cap2_reg;
  logic [1:0]     lock_reg;
  logic           tof_reg;
  logic [1:0]     icf_reg;
  logic           tof_arm_reg;
  logic [1:0]     icf_arm_reg;
  tcic_ctrl1_type ctrl1_reg;
  tcic_ctrl2_type ctrl2_reg;
  logic           pready_reg;
  logic [31:0]    prdata_reg;
  logic           pslverr_reg;
  logic           ovf_irq_reg;
  logic           cap_irq_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Effects act on the edge that raises pready; the master holds its request past it
  logic ev;
  logic rd;
  logic wr;
  assign ev = psel & penable & ~pready_reg;
  assign rd = ev & ~pwrite;
  assign wr = ev & pwrite;
  function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
    at = a == ofs;
  endfunction
  logic acc_cnt_lo;
  logic acc_alt_lo;
  logic rd_hi_any;
  logic rd_lo_any;
  logic rd_status;
  logic [1:0] rd_cap_hi;
  logic [1:0] acc_cap_lo;
  assign acc_cnt_lo = ev & at(paddr, OFS_CNT_LO);
  assign acc_alt_lo = ev & at(paddr, OFS_ALT_LO);
  assign rd_hi_any  = rd & (at(paddr, OFS_CNT_HI) | at(paddr, OFS_ALT_HI));
  assign rd_lo_any  = rd & (at(paddr, OFS_CNT_LO) | at(paddr, OFS_ALT_LO));
  assign rd_status  = rd & at(paddr, OFS_STATUS);
  assign rd_cap_hi  = {rd & at(paddr, OFS_CAP2_HI), rd & at(paddr, OFS_CAP1_HI)};
  assign acc_cap_lo = {ev & at(paddr, OFS_CAP2_LO), ev & at(paddr, OFS_CAP1_LO)};
  logic reload;
  assign reload = wr & (at(paddr, OFS_CNT_LO) | at(paddr, OFS_ALT_LO)); // R3

  // ----------------------------------------------------------------
  // Timer clock
  // ----------------------------------------------------------------
  logic ext_edge;
  logic tick;
  assign ext_edge = edge_hit(ext_prev_reg, external_clock_pin, ctrl2_reg.ext_edge); // R11

  always_comb
  begin
    tick = 1'b0;
    if (ctrl2_reg.clock_select == CS_EXTERNAL)
      tick = ext_edge; // R11 R12
    else if (ctrl2_reg.clock_select == CODE_DIV2)
      tick = div_mask_ok(pre_reg, MASK_DIV2); // R5 R23
    else if (ctrl2_reg.clock_select == CODE_DIV4)
      tick = div_mask_ok(pre_reg, MASK_DIV4); // R5 R23
    else if (ctrl2_reg.clock_select == CODE_DIV8)
      tick = div_mask_ok(pre_reg, MASK_DIV8); // R5 R23
  end

  // Halt freezes the prescaler too, so counting resumes in phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_reg      <= 3'h0;
      ext_prev_reg <= 1'b0;
    end
    else if (!halt_mode)
    begin
      pre_reg      <= pre_reg + 3'h1;
      ext_prev_reg <= external_clock_pin;
    end
  end

  // ----------------------------------------------------------------
  // Counter and read latch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= CNT_RELOAD; // R4
    else if (reload)
      cnt_reg <= CNT_RELOAD; // R3 R4
    else if (tick && !halt_mode)
      cnt_reg <= cnt_reg + 16'h0001; // R1 R10
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_reg       <= 1'b0;
      low_latch_reg <= 8'h00;
    end
    else if (rd_hi_any && !seq_reg)
    begin
      seq_reg       <= 1'b1; // R6
      low_latch_reg <= cnt_reg[7:0];
    end
    else if (rd_lo_any)
      seq_reg <= 1'b0; // R6
  end

  // ----------------------------------------------------------------
  // Flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  logic ovf_set;
  assign ovf_set = tick & ~halt_mode & ~reload & (cnt_reg == CNT_TOP); // R7
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tof_reg     <= 1'b0;
      tof_arm_reg <= 1'b0;
    end
    else
    begin
      if (ovf_set)
        tof_reg <= 1'b1; // R7
      else if (acc_cnt_lo && tof_arm_reg)
        tof_reg <= 1'b0; // R9
      if (rd_status && tof_reg)
        tof_arm_reg <= 1'b1; // R9
      else if (acc_cnt_lo)
        tof_arm_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  logic [1:0] cap_edge;
  logic [1:0] cap_on;
  assign cap_edge[0] = edge_hit(pin_prev_reg[0], pin_s_reg[0], ctrl1_reg.edge_one); // R15 R21
  assign cap_edge[1] = edge_hit(pin_prev_reg[1], pin_s_reg[1], ctrl2_reg.edge_two); // R15 R21
  assign cap_on[0]   = cap_edge[0] & ~lock_reg[0] & ~(ctrl2_reg.one_pulse | ctrl2_reg.pwm); // R19 R20
  assign cap_on[1]   = cap_edge[1] & ~lock_reg[1]; // R19 R20
  // One sampling stage puts the flag two clocks after the pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s_reg    <= 2'h0;
      pin_prev_reg <= 2'h0;
    end
    else
    begin
      pin_s_reg    <= {capture_pin_two, capture_pin_one}; // R22
      pin_prev_reg <= pin_s_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap1_reg <= CNT_RELOAD;
      cap2_reg <= CNT_RELOAD;
    end
    else
    begin
      if (cap_on[0])
        cap1_reg <= cnt_reg; // R14
      if (cap_on[1])
        cap2_reg <= cnt_reg; // R14
    end
  end
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          lock_reg[ch]    <= 1'b0;
          icf_reg[ch]     <= 1'b0;
          icf_arm_reg[ch] <= 1'b0;
        end
        else
        begin
          if (rd_cap_hi[ch])
            lock_reg[ch] <= 1'b1; // R19
          else if (acc_cap_lo[ch] && !pwrite)
            lock_reg[ch] <= 1'b0;
          if (cap_on[ch])
            icf_reg[ch] <= 1'b1; // R16
          else if (acc_cap_lo[ch] && icf_arm_reg[ch])
            icf_reg[ch] <= 1'b0; // R18
          if (rd_status && icf_reg[ch])
            icf_arm_reg[ch] <= 1'b1; // R18
          else if (acc_cap_lo[ch])
            icf_arm_reg[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_irq_reg <= 1'b0;
      cap_irq_reg <= 1'b0;
    end
    else
    begin
      ovf_irq_reg <= tof_reg & ctrl1_reg.ovf_ie & ~cpu_irq_mask; // R8
      cap_irq_reg <= (|icf_reg) & ctrl1_reg.cap_ie & ~cpu_irq_mask; // R16 R17
    end
  end

  // ----------------------------------------------------------------
  // Register file and APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_reg <= '0;
      ctrl2_reg <= '0;
    end
    else if (wr && at(paddr, OFS_CTRL1))
      ctrl1_reg <= pwdata[$bits(tcic_ctrl1_type)-1:0];
    else if (wr && at(paddr, OFS_CTRL2))
      ctrl2_reg <= pwdata[$bits(tcic_ctrl2_type)-1:0];
  end
  logic [7:0] rmux;
  logic       mapped;
  always_comb
  begin
    rmux   = 8'h00;
    mapped = 1'b1;
    case (paddr)
      OFS_CNT_HI, OFS_ALT_HI:
        rmux = cnt_reg[15:8]; // R1 R2
      OFS_CNT_LO, OFS_ALT_LO:
        rmux = seq_reg ? low_latch_reg : cnt_reg[7:0]; // R6
      OFS_STATUS:
        rmux = {5'h00, icf_reg[1], icf_reg[0], tof_reg};
      OFS_CTRL1:
        rmux = {5'h00, ctrl1_reg};
      OFS_CTRL2:
        rmux = {2'h0, ctrl2_reg};
      OFS_CAP1_HI:
        rmux = cap1_reg[15:8];
      OFS_CAP1_LO:
        rmux = cap1_reg[7:0];
      OFS_CAP2_HI:
        rmux = cap2_reg[15:8];
      OFS_CAP2_LO:
        rmux = cap2_reg[7:0];
      default:
        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (ev)
    begin
      pready_reg  <= 1'b1;
      prdata_reg  <= pwrite ? 32'h0000_0000 : {24'h000000, rmux};
      pslverr_reg <= ~mapped;
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign overflow_irq = ovf_irq_reg;
  assign capture_irq  = cap_irq_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reload_on_write: assert property (reload |=> cnt_reg == CNT_RELOAD) // R3
    else $error("low byte write did not reload counter");
  a_overflow_sets: assert property (ovf_set |=> tof_reg && cnt_reg == 16'h0000) // R7
    else $error("rollover did not set overflow flag");
  a_ovf_irq_gate: assert property (overflow_irq |-> $past(tof_reg & ctrl1_reg.ovf_ie & ~cpu_irq_mask)) // R8
    else $error("overflow request without enable and open mask");
  a_alt_keeps_tof: assert property (acc_alt_lo && !ovf_set |=> !$fell(tof_reg)) // R2 R9
    else $error("alternate low access cleared overflow flag");
  a_halt_freeze: assert property (halt_mode && !reload |=> $stable(cnt_reg)) // R10
    else $error("counter moved in halt");
  a_ext_tick: assert property (ctrl2_reg.clock_select == CS_EXTERNAL && !ext_edge |-> !tick) // R11
    else $error("external mode counted without pin edge");
  a_capture_value: assert property (cap_on[1] |=> cap2_reg == $past(cnt_reg)) // R14
    else $error("capture two missed counter value");
  a_lock_blocks: assert property (lock_reg[0] |=> $stable(cap1_reg) && !$rose(icf_reg[0])) // R19
    else $error("capture one changed while locked");
  a_opm_chan_one: assert property (ctrl2_reg.one_pulse || ctrl2_reg.pwm |=> $stable(cap1_reg)) // R20
    else $error("capture one active in pulse mode");
  a_cap_flag_delay: assert property ($changed(capture_pin_two) && capture_pin_two == ctrl2_reg.edge_two // R22
    && !lock_reg[1] && !rd_cap_hi[1] && !(wr && at(paddr, OFS_CTRL2)) |=> ##1 icf_reg[1])
    else $error("capture flag timing off");
  a_latch_holds: assert property (seq_reg && !rd_lo_any |=> $stable(low_latch_reg)) // R6
    else $error("latched low byte changed mid sequence");
  c_overflow: cover property (ovf_set ##1 overflow_irq);
  c_capture_one: cover property (cap_on[0] ##[1:4] capture_irq);
  c_capture_two: cover property (cap_on[1]);
  c_ext_count: cover property (ctrl2_reg.clock_select == CS_EXTERNAL && tick);
endmodule

/* tcic_pins.sv */
`timescale 1ns/1ps
module tcic_pins
(
  input  wire logic pclk,
  output logic      ext_clk,
  output logic      cap_one,
  output logic      cap_two
);
  // --------------------------------------------------------------
  // Edge sources on the clock and capture pins
  // --------------------------------------------------------------
  initial
  begin
    ext_clk = 1'b0;
    cap_one = 1'b0;
    cap_two = 1'b0;
  end

  // Gap is clamped so no caller can run the pin faster than allowed
  task automatic tick(input int n, input int gap);
    int g;
    g = (gap < 4) ? 4 : gap;
    repeat (n)
    begin
      @(posedge pclk);
      ext_clk <= 1'b1;
      repeat (g) @(posedge pclk);
      ext_clk <= 1'b0;
      repeat (g) @(posedge pclk);
    end
  endtask

  // Settle time covers the capture latency before the caller looks
  task automatic set(input int ch, input logic lvl);
    @(posedge pclk);
    if (ch == 1)
      cap_one <= lvl;
    else
      cap_two <= lvl;
    repeat (4) @(posedge pclk);
  endtask
endmodule

/* tcic_tb.sv */
`timescale 1ns/1ps
module testbench;
  import tcic_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        cpu_irq_mask = 1'b1;
  logic        halt_mode = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, ext_clk, cap_one, cap_two, overflow_irq, capture_irq;
  logic [31:0] rd;
  logic        serr;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #2 pclk = ~pclk;

  tcic_top DUT (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .cpu_irq_mask       (cpu_irq_mask),
    .halt_mode          (halt_mode),
    .external_clock_pin (ext_clk),
    .capture_pin_one    (cap_one),
    .capture_pin_two    (cap_two),
    .overflow_irq       (overflow_irq),
    .capture_irq        (capture_irq)
  );

  tcic_pins pins (.pclk(pclk), .ext_clk(ext_clk), .cap_one(cap_one), .cap_two(cap_two));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd   = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_CTRL1, 32'h0);
    rdc(OFS_CAP1_HI, 32'hff);
    rdc(OFS_CAP1_LO, 32'hfc);
    apb(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0);
    check({31'h0, serr}, 32'h1);
  endtask

  // External clock keeps the count static between pulses; the divide-by-2
  // default has already rolled over once since reset, so that flag is cleared first
  task automatic t_overflow();
    wr(OFS_CTRL2, 32'h07);
    rdc(OFS_STATUS, 32'h1);
    wr(OFS_CNT_LO, 32'h0);
    wr(OFS_CTRL1, 32'h01);
    rdc(OFS_CNT_HI, 32'hff);
    rdc(OFS_CNT_LO, 32'hfc);
    pins.tick(3, 4);
    rdc(OFS_STATUS, 32'h0);
    pins.tick(1, 6);
    rdc(OFS_ALT_LO, 32'h00);
    check({31'h0, overflow_irq}, 32'h0);
    @(posedge pclk);
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge pclk);
    check({31'h0, overflow_irq}, 32'h1);
    rdc(OFS_STATUS, 32'h1);
    rdc(OFS_ALT_LO, 32'h00);
    rdc(OFS_STATUS, 32'h1);
    rdc(OFS_CNT_LO, 32'h00);
    rdc(OFS_STATUS, 32'h0);
    repeat (3) @(posedge pclk);
    check({31'h0, overflow_irq}, 32'h0);
  endtask

  task automatic t_latch();
    wr(OFS_CNT_LO, 32'h0);
    rdc(OFS_CNT_HI, 32'hff);
    pins.tick(2, 4);
    rdc(OFS_ALT_HI, 32'hff);
    rdc(OFS_CNT_LO, 32'hfc);
    rdc(OFS_CNT_LO, 32'hfe);
  endtask

  task automatic t_capture();
    wr(OFS_CTRL1, 32'h06);
    pins.set(1, 1'b1);
    check({31'h0, capture_irq}, 32'h1);
    rdc(OFS_STATUS, 32'h2);
    rdc(OFS_CAP1_HI, 32'hff);
    rdc(OFS_CAP1_LO, 32'hfe);
    rdc(OFS_STATUS, 32'h0);
    pins.set(2, 1'b1);
    rdc(OFS_STATUS, 32'h0);
    pins.set(2, 1'b0);
    rdc(OFS_STATUS, 32'h4);
    rdc(OFS_CAP2_HI, 32'hff);
    pins.tick(1, 4);
    pins.set(2, 1'b1);
    pins.set(2, 1'b0);
    rdc(OFS_CAP2_LO, 32'hfe);
    rdc(OFS_STATUS, 32'h0);
    pins.set(2, 1'b1);
    pins.set(2, 1'b0);
    rdc(OFS_CAP2_LO, 32'hff);
    for (int m = 0; m < 2; m++)
    begin
      wr(OFS_CTRL2, (m == 0) ? 32'h17 : 32'h27);
      pins.set(1, 1'b0);
      pins.set(1, 1'b1);
      rdc(OFS_STATUS, 32'h4);
    end
  endtask

  task automatic t_halt();
    wr(OFS_CTRL2, 32'h07);
    @(posedge pclk);
    halt_mode <= 1'b1;
    pins.tick(3, 4);
    halt_mode <= 1'b0;
    rdc(OFS_CNT_LO, 32'hff);
    pins.tick(1, 4);
    rdc(OFS_CNT_LO, 32'h00);
    wr(OFS_CTRL2, 32'h03);
    pins.tick(1, 4);
    rdc(OFS_CNT_LO, 32'h01);
  endtask

  // Prescaler phase is free-running, so the count is judged within a window
  task automatic t_div();
    logic [7:0] n;
    int d;
    for (int i = 0; i < 3; i++)
    begin
      d = 2 << i;
      wr(OFS_CTRL2, i);
      wr(OFS_CNT_LO, 32'h0);
      repeat (40) @(posedge pclk);
      apb(1'b0, OFS_CNT_LO, 32'h0);
      n = rd[7:0] - 8'hfc;
      check({31'h0, (n >= 40 / d && n <= 48 / d)}, 32'h1);
    end
  endtask

  // --------------------------------------------------------------
  // Sequence and timeout
  // --------------------------------------------------------------
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      results();
    end
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_overflow();
    t_latch();
    t_capture();
    t_halt();
    t_div();
    results();
  end
endmodule
